// ---- ibbs_pkg.sv ----
package ibbs_pkg;
	// ============================================================
	// Reset values and timing
	// ============================================================
	localparam logic BUS_BUSY_RST = 1'b0;
	localparam int CLK_PERIOD_NS = 20;
	// Half of a bus bit time used for start/stop setup and hold.
	localparam int COND_HOLD_NS = 5000;
	localparam int COND_HOLD_CYC = (COND_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int CNT_W = 8;
	localparam int SYNC_STAGES = 2;

	typedef enum logic [2:0] {
		IBBS_IDLE = 3'b000,
		IBBS_ST_SETUP = 3'b001,
		IBBS_ST_HOLD = 3'b010,
		IBBS_SP_LOW = 3'b011,
		IBBS_SP_SETUP = 3'b100,
		IBBS_SP_HOLD = 3'b101
	} ibbs_state_t;
endpackage

// ---- ibbs_sync.sv ----
`timescale 1ns/1ps
module ibbs_sync
(
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic async_i,
	output logic sync_o
);
	import ibbs_pkg::*;

	// ============================================================
	// Two-flop synchroniser; idle bus lines sit high.
	// ============================================================
	typedef struct packed {
		logic meta;
		logic sync;
	} ibbs_sync_t;

	ibbs_sync_t st;
	ibbs_sync_t next_st;

	always_comb
	begin
		next_st.meta = async_i;
		next_st.sync = st.meta;
	end

	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			st <= '{meta: 1'b1, sync: 1'b1};
		else
			st <= next_st;
	end

	assign sync_o = st.sync;
endmodule

// ---- ibbs_ctrl.sv ----
`timescale 1ns/1ps
// Overview of operation
// - In slave mode the bus busy flag is readable as bus occupied status.
// - SDA falling while SCL high sets the bus busy flag.
// - SDA rising while SCL high clears the bus busy flag.
// - Writes to the bus busy flag are ignored in slave mode.
// - Master write busy=1 with guard=0 in transmit mode issues a start condition.
// - A repeated start uses the same write as a first start.
module ibbs_ctrl
#(
	parameter int HOLD_CYC = ibbs_pkg::COND_HOLD_CYC
)
(
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic scl_i,
	input wire logic sda_i,
	input wire logic master_i,
	input wire logic transmit_i,
	input wire logic wr_i,
	input wire logic wr_bus_busy_flag_i,
	input wire logic wr_start_stop_write_guard_i,
	output logic bus_busy_flag_o,
	output logic scl_o,
	output logic scl_oe_o,
	output logic sda_o,
	output logic sda_oe_o,
	output logic cond_active_o
);
	import ibbs_pkg::*;

	// The hold counter must be able to hold the configured count.
	if (HOLD_CYC < 1 || HOLD_CYC > (2 ** CNT_W) - 1)
	begin
		$error("HOLD_CYC out of range");
	end

	// ============================================================
	// State
	// ============================================================
	typedef struct packed {
		logic scl_q;
		logic sda_q;
		logic busy;
		ibbs_state_t fsm;
		logic [CNT_W-1:0] cnt;
		logic scl_oe;
		logic sda_oe;
		logic active;
	} ibbs_ctrl_t;

	ibbs_ctrl_t st;
	ibbs_ctrl_t next_st;
	logic scl_s;
	logic sda_s;
	logic start_det;
	logic stop_det;
	logic cnt_done;
	logic wr_ok;

	ibbs_sync u_scl_sync
	(
		.clk_i(clk_i),
		.rst_n_i(rst_n_i),
		.async_i(scl_i),
		.sync_o(scl_s)
	);

	ibbs_sync u_sda_sync
	(
		.clk_i(clk_i),
		.rst_n_i(rst_n_i),
		.async_i(sda_i),
		.sync_o(sda_s)
	);

	assign start_det = st.scl_q && scl_s && st.sda_q && !sda_s;
	assign stop_det = st.scl_q && scl_s && !st.sda_q && sda_s;
	assign cnt_done = (st.cnt == '0);
	// Slave mode drops the write entirely; start also needs transmit mode.
	assign wr_ok = wr_i && master_i && !wr_start_stop_write_guard_i;

	// ============================================================
	// Next state
	// ============================================================
	always_comb
	begin
		next_st = st;
		next_st.scl_q = scl_s;
		next_st.sda_q = sda_s;
		if (!cnt_done)
			next_st.cnt = st.cnt - 1'b1;
		// The flag follows the bus only, so own conditions update it too.
		if (start_det)
			next_st.busy = 1'b1;
		else if (stop_det)
			next_st.busy = 1'b0;
		case (st.fsm)
			IBBS_IDLE:
			begin
				if (wr_ok && wr_bus_busy_flag_i && transmit_i)
				begin
					next_st.fsm = IBBS_ST_SETUP;
					next_st.sda_oe = 1'b0;
					next_st.cnt = CNT_W'(HOLD_CYC);
				end
				else if (wr_ok && !wr_bus_busy_flag_i)
				begin
					next_st.fsm = IBBS_SP_LOW;
					next_st.sda_oe = 1'b1;
					next_st.cnt = CNT_W'(HOLD_CYC);
				end
			end
			IBBS_ST_SETUP:
			begin
				// SDA is let go first while SCL stays low, so that a repeated
				// start can never look like a stop to the other devices.
				if (st.scl_oe)
				begin
					if (cnt_done)
					begin
						next_st.scl_oe = 1'b0;
						next_st.cnt = CNT_W'(HOLD_CYC);
					end
				end
				// Released SDA and SCL must be seen high before SDA falls.
				else if (cnt_done && scl_s && sda_s)
				begin
					next_st.fsm = IBBS_ST_HOLD;
					next_st.sda_oe = 1'b1;
					next_st.cnt = CNT_W'(HOLD_CYC);
				end
			end
			IBBS_ST_HOLD:
			begin
				if (cnt_done)
				begin
					next_st.fsm = IBBS_IDLE;
					next_st.scl_oe = 1'b1;
				end
			end
			IBBS_SP_LOW:
			begin
				if (cnt_done)
				begin
					next_st.fsm = IBBS_SP_SETUP;
					next_st.scl_oe = 1'b0;
					next_st.cnt = CNT_W'(HOLD_CYC);
				end
			end
			IBBS_SP_SETUP:
			begin
				if (cnt_done && scl_s)
				begin
					next_st.fsm = IBBS_SP_HOLD;
					next_st.sda_oe = 1'b0;
					next_st.cnt = CNT_W'(HOLD_CYC);
				end
			end
			IBBS_SP_HOLD:
			begin
				if (cnt_done)
					next_st.fsm = IBBS_IDLE;
			end
			default:
			begin
				next_st.fsm = IBBS_IDLE;
				next_st.scl_oe = 1'b0;
				next_st.sda_oe = 1'b0;
			end
		endcase
		next_st.active = (next_st.fsm != IBBS_IDLE);
	end

	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			st <= '{scl_q: 1'b1, sda_q: 1'b1, busy: BUS_BUSY_RST, fsm: IBBS_IDLE,
				cnt: '0, scl_oe: 1'b0, sda_oe: 1'b0, active: 1'b0};
		else
			st <= next_st;
	end

	assign bus_busy_flag_o = st.busy;
	assign scl_o = 1'b0;
	assign sda_o = 1'b0;
	assign scl_oe_o = st.scl_oe;
	assign sda_oe_o = st.sda_oe;
	assign cond_active_o = st.active;

	// ============================================================
	// Checks
	// ============================================================
	sequence s_start_seen;
		start_det;
	endsequence

	sequence s_stop_seen;
		stop_det;
	endsequence

	AST_START_SETS: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		s_start_seen |=> bus_busy_flag_o)
		else $error("Busy flag not set after start.");

	AST_STOP_CLEARS: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		s_stop_seen |=> !bus_busy_flag_o)
		else $error("Busy flag not cleared after stop.");

	AST_FLAG_STABLE: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		!start_det && !stop_det |=> $stable(bus_busy_flag_o))
		else $error("Busy flag changed without bus condition.");

	AST_SLAVE_IGNORE: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		wr_i && !master_i && !cond_active_o |=> !cond_active_o)
		else $error("Slave write started a condition.");

	AST_RESTART_NO_STOP: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		st.fsm == IBBS_ST_SETUP |-> !stop_det)
		else $error("Stop seen while setting up a start.");

	AST_START_ISSUE: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		!cond_active_o && wr_i && master_i && transmit_i && wr_bus_busy_flag_i
		&& !wr_start_stop_write_guard_i |=> st.fsm == IBBS_ST_SETUP)
		else $error("Start request not taken.");

	AST_GUARD_BLOCKS: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		!cond_active_o && wr_i && wr_start_stop_write_guard_i |=> !cond_active_o)
		else $error("Guarded write started a condition.");

	AST_RX_NO_START: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		!cond_active_o && wr_i && !transmit_i && wr_bus_busy_flag_i |=> !cond_active_o)
		else $error("Start issued outside transmit mode.");

	AST_STOP_ISSUE: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		!cond_active_o && wr_i && master_i && !wr_bus_busy_flag_i
		&& !wr_start_stop_write_guard_i |=> sda_oe_o ##1 st.fsm == IBBS_SP_LOW)
		else $error("Stop request not taken.");
endmodule

// ---- ibbs_peer.sv ----
`timescale 1ns/1ps
module ibbs_peer
(
	output logic scl_pull_o,
	output logic sda_pull_o
);
	// ============================================================
	// Other master on the bus
	// ============================================================
	// Steps are 80 ns apart; both lines are released between frames.
	initial
	begin
		scl_pull_o = 1'b0;
		sda_pull_o = 1'b0;
	end
	task automatic gen_start();
		#80 sda_pull_o = 1'b1;
		#80 scl_pull_o = 1'b1;
	endtask
	task automatic gen_stop();
		#80 sda_pull_o = 1'b1;
		#80 scl_pull_o = 1'b0;
		#80 sda_pull_o = 1'b0;
		#80;
	endtask
endmodule

// ---- testbench.sv ----
`timescale 1ns/1ps
module testbench;
	import ibbs_pkg::*;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic master = 1'b0;
	logic transmit = 1'b0;
	logic wr = 1'b0;
	logic wr_busy = 1'b0;
	logic wr_guard = 1'b0;
	logic busy, scl_oe, sda_oe, act, p_scl, p_sda;
	logic scl_d, sda_d;
	wire scl;
	wire sda;
	int err_count = 0;
	int n_compared = 0;
	// ============================================================
	// Bus wiring
	// ============================================================
	// Open drain with pull-ups: any party pulling wins.
	assign scl = ~((scl_oe & ~scl_d) | p_scl);
	assign sda = ~((sda_oe & ~sda_d) | p_sda);
	ibbs_peer peer (.scl_pull_o(p_scl), .sda_pull_o(p_sda));
	ibbs_ctrl #(.HOLD_CYC(4)) uut (.clk_i(clk), .rst_n_i(rst_n), .scl_i(scl), .sda_i(sda),
		.master_i(master), .transmit_i(transmit), .wr_i(wr), .wr_bus_busy_flag_i(wr_busy),
		.wr_start_stop_write_guard_i(wr_guard), .bus_busy_flag_o(busy), .scl_o(scl_d),
		.scl_oe_o(scl_oe), .sda_o(sda_d), .sda_oe_o(sda_oe), .cond_active_o(act));
	initial
	begin
		forever #10 clk = ~clk;
	end
	// ============================================================
	// Tasks
	// ============================================================
	task automatic chk(input logic seen, input logic exp);
		n_compared++;
		if (seen !== exp)
		begin
			err_count++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic finish_test();
		$display("errors %0d compares %0d", err_count, n_compared);
		if (err_count == 0 && n_compared > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	// One write, then one more edge so a started sequence is visible.
	task automatic write(input logic b, input logic g);
		@(negedge clk);
		wr = 1'b1;
		wr_busy = b;
		wr_guard = g;
		@(negedge clk);
		wr = 1'b0;
		@(negedge clk);
	endtask
	task automatic wait_done();
		for (int i = 0; i < 200 && act === 1'b1; i++)
			@(negedge clk);
		repeat (8) @(negedge clk);
	endtask
	// ============================================================
	// Tests
	// ============================================================
	initial
	begin
		#200000;
		err_count++;
		finish_test();
	end
	initial
	begin
		repeat (3) @(negedge clk);
		rst_n = 1'b1;
		repeat (4) @(negedge clk);
		chk(busy, BUS_BUSY_RST);
		peer.gen_start();
		repeat (8) @(negedge clk);
		chk(busy, 1'b1);
		write(1'b0, 1'b0);
		repeat (8) @(negedge clk);
		chk(busy, 1'b1);
		chk(act, 1'b0);
		peer.gen_stop();
		repeat (8) @(negedge clk);
		chk(busy, 1'b0);
		master = 1'b1;
		write(1'b1, 1'b0);
		chk(act, 1'b0);
		transmit = 1'b1;
		write(1'b1, 1'b1);
		chk(act, 1'b0);
		write(1'b1, 1'b0);
		chk(act, 1'b1);
		wait_done();
		chk(busy, 1'b1);
		chk(sda_oe, 1'b1);
		chk(scl_oe, 1'b1);
		write(1'b1, 1'b0);
		chk(act, 1'b1);
		wait_done();
		chk(sda_oe, 1'b1);
		chk(busy, 1'b1);
		chk(scl_oe, 1'b1);
		write(1'b0, 1'b0);
		chk(act, 1'b1);
		wait_done();
		chk(busy, 1'b0);
		chk(scl_oe | sda_oe, 1'b0);
		finish_test();
	end
endmodule
